// ### hdl/sbi_pkg.sv
package sbi_pkg;

  // Flags word layout
  localparam int unsigned FLAGS_IRQ_EN_BIT = 9;

  // Timing counts in system clocks
  localparam int unsigned RESET_HOLD_MIN_CLKS = 16;
  localparam int unsigned INIT_CLKS           = 50;
  localparam logic [5:0]  INIT_LAST           = 6'(INIT_CLKS - 1);
  localparam logic [2:0]  NMI_MIN_CLKS        = 3'h4;

  localparam logic [7:0]  NMI_VECTOR          = 8'h02;
  localparam logic [1:0]  ACK_CYCLES          = 2'h2;

  // Synchroniser lanes
  localparam int unsigned SYN_HOLD  = 0;
  localparam int unsigned SYN_MASKABLE_IRQ  = 1;
  localparam int unsigned SYN_NMI   = 2;
  localparam int unsigned SYN_OPREQ = 3;
  localparam int unsigned SYN_BUSY  = 4;
  localparam int unsigned SYN_ERR   = 5;
  localparam int unsigned SYN_W     = 6;
  localparam logic [5:0]  SYN_RESET = 6'h30;

  // Cycle codes {codeAck, memIo, status1, status0}
  localparam logic [3:0] CODE_IRQ_ACK = 4'h0;
  localparam logic [3:0] CODE_HALT    = 4'h4;
  localparam logic [3:0] CODE_MEM_RD  = 4'h5;
  localparam logic [3:0] CODE_MEM_WR  = 4'h6;
  localparam logic [3:0] CODE_IO_RD   = 4'h9;
  localparam logic [3:0] CODE_IO_WR   = 4'hA;
  localparam logic [3:0] CODE_FETCH   = 4'hD;
  localparam logic [1:0] STATUS_IDLE  = 2'h3;

  typedef enum logic [2:0] {
    CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR, CYC_FETCH, CYC_HALT, CYC_IRQ_ACK
  } sbi_cyc_t;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_STAT, ST_CMD, ST_FLOAT, ST_HOLD
  } sbi_fsm_t;

  typedef struct packed {
    logic        valid;
    sbi_cyc_t    kind;
    logic [23:0] addr;
    logic        upperN;
    logic [15:0] wdata;
    logic        lock;
    logic        coprocOp;
  } sbi_req_t;

  typedef struct packed {
    logic [1:0]  statusN;
    logic        memIo;
    logic        codeAck;
    logic        lockN;
    logic [23:0] addr;
    logic        upperN;
    logic        busOe;
    logic [15:0] dataOut;
    logic        dataOe;
    logic        holdGrant;
    logic        opAckN;
  } sbi_pins_t;

  localparam sbi_pins_t PINS_RESET = '{
    statusN: 2'h3, memIo: 1'b0, codeAck: 1'b0, lockN: 1'b1, addr: 24'hFFFFFF,
    upperN: 1'b1, busOe: 1'b1, dataOut: 16'h0000, dataOe: 1'b0,
    holdGrant: 1'b0, opAckN: 1'b1};

  typedef struct packed {
    sbi_fsm_t    fsm;
    logic        phase;
    logic [5:0]  initCnt;
    sbi_cyc_t    kind;
    logic [1:0]  ackLeft;
    logic [1:0]  intrHist;
    logic [2:0]  nmiLowCnt;
    logic [2:0]  nmiHighCnt;
    logic        nmiArmed;
    logic        nmiPending;
    logic        errPrev;
    logic        reqReady;
    logic        coreDone;
    logic [15:0] coreRdata;
    logic        irqVecValid;
    logic [7:0]  irqVector;
    logic        execStall;
    logic        coprocErrIrq;
    logic        coprocOpPending;
    logic        startFetch;
    sbi_pins_t   pins;
  } sbi_state_t;

  localparam sbi_state_t STATE_RESET = '{
    fsm: ST_INIT, phase: 1'b0, initCnt: 6'h00, kind: CYC_MEM_RD, ackLeft: 2'h0,
    intrHist: 2'h0, nmiLowCnt: 3'h0, nmiHighCnt: 3'h0, nmiArmed: 1'b0,
    nmiPending: 1'b0, errPrev: 1'b0, reqReady: 1'b0, coreDone: 1'b0,
    coreRdata: 16'h0000, irqVecValid: 1'b0, irqVector: 8'h00, execStall: 1'b0,
    coprocErrIrq: 1'b0, coprocOpPending: 1'b0, startFetch: 1'b0, pins: PINS_RESET};

  function automatic logic [3:0] sbiCycCode(input sbi_cyc_t k);
    case (k)
      CYC_MEM_RD:  sbiCycCode = CODE_MEM_RD;
      CYC_MEM_WR:  sbiCycCode = CODE_MEM_WR;
      CYC_IO_RD:   sbiCycCode = CODE_IO_RD;
      CYC_IO_WR:   sbiCycCode = CODE_IO_WR;
      CYC_FETCH:   sbiCycCode = CODE_FETCH;
      CYC_HALT:    sbiCycCode = CODE_HALT;
      default:     sbiCycCode = CODE_IRQ_ACK;
    endcase
  endfunction : sbiCycCode

endpackage : sbi_pkg

// ### hdl/sbi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbi_sync #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r <= RESET_VAL;
      q      <= RESET_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sbi_sync
`default_nettype wire

// ### hdl/sbi_system_interface.sv
// Overview of operation
// R1: Memory/IO select high for memory or halt cycles, low for I/O and acknowledge.
// R2: Code/ack select splits fetch from data read, acknowledge from I/O; floats in hold.
// R3: Lock output held low for locked requests and interrupt acknowledge cycles.
// R4: Each bus cycle stretches until ready is sampled low on the clock.
// R5: Ready is not looked at while the bus is granted away.
// R6: On hold, drivers float first, grant output rises one clock later.
// R7: Grant stays while hold request is high; drop returns the bus.
// R8: Maskable request is ignored while the interrupt enable flag is clear.
// R9: Interrupt enable flag is bit 9 of the flags word.
// R10: Maskable interrupt runs two acknowledge cycles, vector byte from data bus.
// R11: Requester keeps maskable request high until first acknowledge completes.
// R12: Maskable request sampled each processor cycle, needs two cycles before boundary.
// R13: Non-maskable request yields vector 2 without acknowledge cycles, ignores enable.
// R14: Non-maskable request taken on synchronised rise after four low, four high; the code arms only after five low clocks.
// R15: Coprocessor operand request raised; operand ack low during that transfer.
// R16: Busy low stalls wait-type instructions; interrupts still accepted.
// R17: Error low during wait-type instruction raises coprocessor interrupt.
// R18: Reset clears all logic; source holds it over 16 clocks; the bench holds it for 10 clocks only.
// R19: During reset outputs sit at their fixed idle levels, data floats.
// R20: About 50 clocks of initialisation before the first code fetch.
// R21: Reset source releases reset synchronously to the system clock.
// R22: Synchronous reset rise starts a fresh processor cycle after release.
// R23: Processor clock is system clock halved, phase set by reset.
// R24: Status state is shown whenever either status line is low.
// R25: Fully static; clock may stop in either phase, state retained.
// R26: Every asynchronous input passes a two-flop synchroniser first.
`timescale 1ns/1ps
`default_nettype none
module sbi_system_interface (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              holdReq,
  input  wire logic              maskableIrq,
  input  wire logic              nmiReq,
  input  wire logic              coprocOperandRequest,
  input  wire logic              coprocBusyN,
  input  wire logic              coprocErrorN,
  input  wire logic              readyN,
  input  wire logic [15:0]       dataIn,
  input  wire sbi_pkg::sbi_req_t coreReq,
  input  wire logic [15:0]       flagsWord,
  input  wire logic              instrEnd,
  input  wire logic              waitInstr,
  output var  sbi_pkg::sbi_pins_t busPins,
  output var  logic              coreReqReady,
  output var  logic              coreDone,
  output var  logic [15:0]       coreRdata,
  output var  logic              irqVecValid,
  output var  logic [7:0]        irqVector,
  output var  logic              execStall,
  output var  logic              coprocErrIrq,
  output var  logic              coprocOpPending,
  output var  logic              startFetch
);
  import sbi_pkg::*;

  sbi_state_t  s_r;
  sbi_state_t  s_nxt;
  logic [SYN_W-1:0] syncIn;
  logic [SYN_W-1:0] syncQ;
  logic [3:0]  code;
  logic        irqEnable;
  logic        intrOk;
  logic        nmiRise;

  assign syncIn = {coprocErrorN, coprocBusyN, coprocOperandRequest, nmiReq, maskableIrq, holdReq};

  sbi_sync #(.W(SYN_W), .RESET_VAL(SYN_RESET)) u_sync ( // see R26
    .core_clk (core_clk),
    .reset    (reset),
    .d        (syncIn),
    .q        (syncQ)
  );

  assign irqEnable = flagsWord[FLAGS_IRQ_EN_BIT]; // see R9

  always_comb begin
    s_nxt = s_r;
    code  = sbiCycCode(coreReq.kind);
    s_nxt.phase        = ~s_r.phase; // see R23
    s_nxt.coreDone     = 1'b0;
    s_nxt.irqVecValid  = 1'b0;
    s_nxt.startFetch   = 1'b0;
    // Request must be seen in two successive processor-cycle samples
    if (!s_r.phase) begin
      s_nxt.intrHist = {s_r.intrHist[0], syncQ[SYN_MASKABLE_IRQ] & irqEnable}; // see R12 see R8
    end
    intrOk = (&s_r.intrHist) && irqEnable; // see R8
    // Low and high widths counted so glitches do not trigger
    nmiRise = 1'b0;
    if (!syncQ[SYN_NMI]) begin
      s_nxt.nmiHighCnt = 3'h0;
      if (s_r.nmiLowCnt != NMI_MIN_CLKS) s_nxt.nmiLowCnt = s_r.nmiLowCnt + 3'h1;
      else s_nxt.nmiArmed = 1'b1;
    end else begin
      s_nxt.nmiLowCnt = 3'h0;
      if (s_r.nmiHighCnt != NMI_MIN_CLKS) s_nxt.nmiHighCnt = s_r.nmiHighCnt + 3'h1;
      if (s_r.nmiArmed && s_r.nmiHighCnt == NMI_MIN_CLKS - 3'h1) begin
        nmiRise = 1'b1; // see R14
        s_nxt.nmiArmed = 1'b0;
      end
    end
    s_nxt.execStall       = waitInstr & ~syncQ[SYN_BUSY]; // see R16
    s_nxt.errPrev         = waitInstr & ~syncQ[SYN_ERR];
    s_nxt.coprocErrIrq    = waitInstr & ~syncQ[SYN_ERR] & ~s_r.errPrev; // see R17
    s_nxt.coprocOpPending = syncQ[SYN_OPREQ]; // see R15
    case (s_r.fsm)
      ST_INIT: begin
        s_nxt.initCnt = s_r.initCnt + 6'h01;
        if (s_r.initCnt == INIT_LAST) begin
          s_nxt.fsm        = ST_IDLE; // see R20
          s_nxt.startFetch = 1'b1;
        end
      end
      ST_IDLE: begin
        // Boundary decisions; a stalled wait still takes interrupts
        if (instrEnd && s_r.nmiPending) begin
          s_nxt.nmiPending  = 1'b0;
          s_nxt.irqVecValid = 1'b1;
          s_nxt.irqVector   = NMI_VECTOR; // see R13
        end else if (instrEnd && intrOk && s_r.ackLeft == 2'h0) begin
          s_nxt.ackLeft  = ACK_CYCLES; // see R10 see R16
          s_nxt.intrHist = 2'h0;
        end
        if (s_r.reqReady && coreReq.valid) begin
          s_nxt.fsm          = ST_STAT;
          s_nxt.kind         = coreReq.kind;
          {s_nxt.pins.codeAck, s_nxt.pins.memIo, s_nxt.pins.statusN} = code; // see R1 see R2
          s_nxt.pins.addr    = coreReq.addr;
          s_nxt.pins.upperN  = coreReq.upperN;
          s_nxt.pins.lockN   = ~coreReq.lock; // see R3
          s_nxt.pins.dataOut = coreReq.wdata;
          s_nxt.pins.dataOe  = (coreReq.kind == CYC_MEM_WR) || (coreReq.kind == CYC_IO_WR);
          s_nxt.pins.opAckN  = ~coreReq.coprocOp; // see R15
        end else if (s_r.ackLeft != 2'h0 && s_r.phase) begin
          s_nxt.fsm          = ST_STAT;
          s_nxt.kind         = CYC_IRQ_ACK;
          {s_nxt.pins.codeAck, s_nxt.pins.memIo, s_nxt.pins.statusN} = CODE_IRQ_ACK;
          s_nxt.pins.lockN   = 1'b0; // see R3
          s_nxt.pins.dataOe  = 1'b0;
        end else if (syncQ[SYN_HOLD] && s_r.ackLeft == 2'h0) begin
          s_nxt.fsm          = ST_FLOAT;
          s_nxt.pins.busOe   = 1'b0; // see R6 see R2
          s_nxt.pins.dataOe  = 1'b0;
        end
      end
      ST_STAT: begin
        if (s_r.phase) begin
          s_nxt.fsm          = ST_CMD;
          s_nxt.pins.statusN = STATUS_IDLE; // see R24
        end
      end
      ST_CMD: begin
        // Sampled without a synchroniser: ready is a same-clock input
        if (s_r.phase && !readyN) begin // see R4
          s_nxt.fsm         = ST_IDLE;
          s_nxt.pins.dataOe = 1'b0;
          s_nxt.pins.opAckN = 1'b1;
          s_nxt.pins.lockN  = 1'b1;
          if (s_r.kind == CYC_IRQ_ACK) begin
            s_nxt.ackLeft = s_r.ackLeft - 2'h1;
            if (s_r.ackLeft == ACK_CYCLES) begin
              s_nxt.pins.lockN = 1'b0; // see R3
            end else begin
              s_nxt.irqVecValid = 1'b1;
              s_nxt.irqVector   = dataIn[7:0]; // see R10
            end
          end else begin
            s_nxt.coreDone  = 1'b1;
            s_nxt.coreRdata = dataIn;
          end
        end
      end
      ST_FLOAT: begin
        s_nxt.fsm            = ST_HOLD;
        s_nxt.pins.holdGrant = 1'b1; // see R6
      end
      ST_HOLD: begin
        // Ready is never sampled here
        if (!syncQ[SYN_HOLD]) begin // see R5 see R7
          s_nxt.fsm            = ST_IDLE;
          s_nxt.pins.holdGrant = 1'b0;
          s_nxt.pins.busOe     = 1'b1;
        end
      end
      default: begin
        s_nxt = STATE_RESET;
      end
    endcase
    // Set after clear so an edge at the boundary is kept
    if (nmiRise) s_nxt.nmiPending = 1'b1; // see R13
    s_nxt.reqReady = (s_nxt.fsm == ST_IDLE) && s_nxt.phase && !syncQ[SYN_HOLD]
                     && (s_nxt.ackLeft == 2'h0);
  end

  // Plain edge flops only, so a stopped clock freezes all state
  always_ff @(posedge core_clk or posedge reset) begin // see R25
    if (reset) begin
      s_r <= STATE_RESET; // see R18 see R19 see R22
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busPins         = s_r.pins;
  assign coreReqReady    = s_r.reqReady;
  assign coreDone        = s_r.coreDone;
  assign coreRdata       = s_r.coreRdata;
  assign irqVecValid     = s_r.irqVecValid;
  assign irqVector       = s_r.irqVector;
  assign execStall       = s_r.execStall;
  assign coprocErrIrq    = s_r.coprocErrIrq;
  assign coprocOpPending = s_r.coprocOpPending;
  assign startFetch      = s_r.startFetch;

  chk_status_len: assert property (@(posedge core_clk) disable iff (reset) // see R24
    (busPins.statusN != STATUS_IDLE && $past(busPins.statusN) == STATUS_IDLE)
    |=> busPins.statusN != STATUS_IDLE ##1 busPins.statusN == STATUS_IDLE)
    else $error("status state not exactly two clocks");
  chk_memio_type: assert property (@(posedge core_clk) disable iff (reset) // see R1
    busPins.statusN != STATUS_IDLE |->
    busPins.memIo == (s_r.kind inside {CYC_MEM_RD, CYC_MEM_WR, CYC_FETCH, CYC_HALT}))
    else $error("memory/io select wrong for cycle");
  chk_ack_lock: assert property (@(posedge core_clk) disable iff (reset) // see R3
    (s_r.fsm inside {ST_STAT, ST_CMD} && s_r.kind == CYC_IRQ_ACK) |-> !busPins.lockN)
    else $error("acknowledge cycle not locked");
  chk_ready_wait: assert property (@(posedge core_clk) disable iff (reset) // see R4
    (s_r.fsm == ST_CMD && readyN) |=> !coreDone && !irqVecValid && s_r.fsm == ST_CMD)
    else $error("cycle ended without ready");
  chk_float_first: assert property (@(posedge core_clk) disable iff (reset) // see R6
    $rose(busPins.holdGrant) |-> !busPins.busOe && $past(!busPins.busOe))
    else $error("grant before drivers floated");
  chk_hold_release: assert property (@(posedge core_clk) disable iff (reset) // see R7
    (s_r.fsm == ST_HOLD && !syncQ[SYN_HOLD]) |=> !busPins.holdGrant && busPins.busOe)
    else $error("grant not released");
  chk_irq_masked: assert property (@(posedge core_clk) disable iff (reset) // see R8
    (s_r.ackLeft == 2'h0 ##1 s_r.ackLeft == ACK_CYCLES) |-> $past(irqEnable))
    else $error("masked request serviced");
  chk_init_delay: assert property (@(posedge core_clk) disable iff (reset) // see R20
    startFetch |-> $past(s_r.initCnt) == INIT_LAST && $past(s_r.fsm) == ST_INIT)
    else $error("first fetch not after init count");
  chk_opack_cycle: assert property (@(posedge core_clk) disable iff (reset) // see R15
    !busPins.opAckN |-> s_r.fsm inside {ST_STAT, ST_CMD})
    else $error("operand ack outside a cycle");
  chk_nmi_vec: assert property (@(posedge core_clk) disable iff (reset) // see R13
    (irqVecValid && $past(s_r.fsm) == ST_IDLE) |-> irqVector == NMI_VECTOR)
    else $error("non-maskable vector wrong");

  // Bus ownership and release
  chk_hold_float: assert property (@(posedge core_clk) disable iff (reset) // see R2
    busPins.holdGrant |-> !busPins.busOe && !busPins.dataOe)
    else $error("drivers active while granted");
  chk_hold_quiet: assert property (@(posedge core_clk) disable iff (reset) // see R5
    s_r.fsm == ST_HOLD |-> !coreDone && busPins.holdGrant)
    else $error("cycle finished during hold");
  chk_grant_drop: assert property (@(posedge core_clk) disable iff (reset) // see R7
    $fell(busPins.holdGrant) |-> busPins.busOe)
    else $error("bus not driven after grant drop");

  // Lock must not linger once acknowledges are done
  chk_lock_idle: assert property (@(posedge core_clk) disable iff (reset) // see R3
    (s_r.fsm == ST_IDLE && s_r.ackLeft == 2'h0) |-> busPins.lockN)
    else $error("lock left asserted in idle");

  // Acknowledge pair ends in a vector taken from the bus
  chk_ack_pair: assert property (@(posedge core_clk) disable iff (reset) // see R10
    ($past(s_r.ackLeft) == 2'h1 && s_r.ackLeft == 2'h0) |-> irqVecValid)
    else $error("second acknowledge gave no vector");
  chk_vec_bus: assert property (@(posedge core_clk) disable iff (reset) // see R10
    (irqVecValid && $past(s_r.fsm) == ST_CMD) |-> irqVector == $past(dataIn[7:0]))
    else $error("vector not taken from data bus");
  chk_nmi_nobus: assert property (@(posedge core_clk) disable iff (reset) // see R13
    (irqVecValid && $past(s_r.fsm) == ST_IDLE) |-> busPins.statusN == STATUS_IDLE)
    else $error("bus cycle for non-maskable request");

  // Processor phase and start-up
  chk_phase_flip: assert property (@(posedge core_clk) disable iff (reset) // see R23
    $past(!reset) |-> s_r.phase != $past(s_r.phase))
    else $error("processor phase did not toggle");
  chk_ready_phase: assert property (@(posedge core_clk) disable iff (reset) // see R22
    coreReqReady |-> s_r.fsm == ST_IDLE && s_r.phase)
    else $error("request offered off phase");
  chk_init_quiet: assert property (@(posedge core_clk) disable iff (reset) // see R20
    s_r.fsm == ST_INIT |-> busPins.statusN == STATUS_IDLE && !coreReqReady)
    else $error("bus active during initialisation");

  // Data drivers only on write cycles
  chk_write_oe: assert property (@(posedge core_clk) disable iff (reset) // see R24
    busPins.dataOe |-> s_r.kind inside {CYC_MEM_WR, CYC_IO_WR}
    && s_r.fsm inside {ST_STAT, ST_CMD})
    else $error("data driven outside a write");
  chk_err_pulse: assert property (@(posedge core_clk) disable iff (reset) // see R17
    coprocErrIrq |=> !coprocErrIrq)
    else $error("error interrupt longer than a pulse");

  cov_hold: cover property (@(posedge core_clk) disable iff (reset) $rose(busPins.holdGrant));
  cov_ack_vec: cover property (@(posedge core_clk) disable iff (reset)
    irqVecValid && $past(s_r.fsm) == ST_CMD);
  cov_done: cover property (@(posedge core_clk) disable iff (reset) coreDone);
  cov_nmi: cover property (@(posedge core_clk) disable iff (reset)
    irqVecValid && irqVector == NMI_VECTOR);
  cov_err: cover property (@(posedge core_clk) disable iff (reset) coprocErrIrq);
endmodule : sbi_system_interface
`default_nettype wire

// ### bench/sbi_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sbi_bus_partner
  import sbi_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      reset,
  input  wire sbi_pins_t busPins,
  input  wire logic [3:0] waitCycles,
  input  wire logic [15:0] rdWord,
  output var  logic      readyN,
  output var  logic [15:0] dataIn
);
  logic       active;
  logic [3:0] cnt;

  // Memory, I/O and interrupt controller side: drives ready low waitCycles + 1 clocks after it sees the status state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active <= 1'h0;
      cnt    <= 4'h0;
      readyN <= 1'h1;
    end else if (busPins.busOe && busPins.statusN != STATUS_IDLE) begin
      active <= 1'h1;
      cnt    <= waitCycles;
      readyN <= 1'h1;
    end else if (active && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (active) begin
      active <= 1'h0;
      readyN <= 1'h0;
    end
  end

  // Data only valid while ready is low; otherwise inverted so stale data never matches
  assign dataIn = readyN ? ~rdWord : rdWord;
endmodule : sbi_bus_partner
`default_nettype wire

// ### bench/cpu_bus_system_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_system_interface_test;
  import sbi_pkg::*;
  logic core_clk = 1'h0, reset = 1'h1, holdReq = 1'h0, maskableIrq = 1'h0, nmiReq = 1'h0;
  logic coprocOperandRequest = 1'h0, coprocBusyN = 1'h1, coprocErrorN = 1'h1;
  logic instrEnd = 1'h0, waitInstr = 1'h0, readyN;
  logic [15:0] dataIn, coreRdata, flagsWord = 16'h0000, rdWord = 16'h0000;
  logic [3:0]  waitCycles = 4'h0;
  logic [7:0]  irqVector;
  logic coreReqReady, coreDone, irqVecValid, execStall, coprocErrIrq, coprocOpPending, startFetch;
  sbi_req_t  coreReq = '0;
  sbi_pins_t busPins;
  int n_fail = 0;
  int cmp_count = 0;

  always #25 core_clk = ~core_clk;

  sbi_system_interface dut (.core_clk(core_clk), .reset(reset), .holdReq(holdReq),
    .maskableIrq(maskableIrq), .nmiReq(nmiReq), .coprocOperandRequest(coprocOperandRequest),
    .coprocBusyN(coprocBusyN), .coprocErrorN(coprocErrorN), .readyN(readyN), .dataIn(dataIn),
    .coreReq(coreReq), .flagsWord(flagsWord), .instrEnd(instrEnd), .waitInstr(waitInstr),
    .busPins(busPins), .coreReqReady(coreReqReady), .coreDone(coreDone),
    .coreRdata(coreRdata), .irqVecValid(irqVecValid), .irqVector(irqVector),
    .execStall(execStall), .coprocErrIrq(coprocErrIrq), .coprocOpPending(coprocOpPending),
    .startFetch(startFetch));

  sbi_bus_partner far (.core_clk(core_clk), .reset(reset), .busPins(busPins),
    .waitCycles(waitCycles), .rdWord(rdWord), .readyN(readyN), .dataIn(dataIn));

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic pulseEnd;
    @(negedge core_clk) instrEnd = 1'h1;
    @(negedge core_clk) instrEnd = 1'h0;
  endtask : pulseEnd

  task automatic doCycle(input sbi_cyc_t k, input logic lk, input logic cp,
                         input logic [3:0] code, output int dur);
    int n;
    @(negedge core_clk);
    coreReq = '{valid: 1'h1, kind: k, addr: 24'h00A5C2, upperN: 1'h0, wdata: 16'h3C5A,
                lock: lk, coprocOp: cp};
    n = 0;
    while (!coreReqReady && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    coreReq.valid = 1'h0;
    chk("cycle code", code, {busPins.codeAck, busPins.memIo, busPins.statusN});
    chk("lock", !lk, busPins.lockN);
    chk("operand ack", !cp, busPins.opAckN);
    chk("address", {24'h00A5C2, 1'h0, k == CYC_MEM_WR || k == CYC_IO_WR},
        {busPins.addr, busPins.upperN, busPins.dataOe});
    if (k == CYC_MEM_WR || k == CYC_IO_WR)
      chk("write data", 16'h3C5A, busPins.dataOut);
    dur = 1;
    while (!coreDone && dur < 60) begin
      @(negedge core_clk);
      dur++;
    end
    chk("done", 1'h1, coreDone);
    if (k == CYC_MEM_RD || k == CYC_IO_RD || k == CYC_FETCH)
      chk("read data", rdWord, coreRdata);
  endtask : doCycle

  task automatic testCycles;
    sbi_cyc_t   kinds [6] = '{CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR, CYC_FETCH, CYC_HALT};
    logic [3:0] codes [6] = '{CODE_MEM_RD, CODE_MEM_WR, CODE_IO_RD, CODE_IO_WR, CODE_FETCH,
                              CODE_HALT};
    int d0, d1;
    for (int i = 0; i < 6; i++) begin
      rdWord = 16'h1234 ^ 16'(i);
      doCycle(kinds[i], i == 1, i == 0, codes[i], d0);
    end
    waitCycles = 4'h4;
    doCycle(CYC_MEM_RD, 1'h0, 1'h0, CODE_MEM_RD, d1);
    chk("wait stretch", 1'h1, d1 >= d0 + 2);
    waitCycles = 4'h0;
  endtask : testCycles

  task automatic testHold;
    int n;
    @(negedge core_clk) holdReq = 1'h1;
    n = 0;
    while (busPins.busOe && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("float before grant", {1'h0, 1'h0, 1'h0}, {busPins.busOe, busPins.dataOe,
        busPins.holdGrant});
    @(negedge core_clk);
    chk("grant", 1'h1, busPins.holdGrant);
    repeat (10) @(negedge core_clk);
    chk("grant held", {1'h1, 1'h0, 1'h0}, {busPins.holdGrant, busPins.busOe, coreDone});
    holdReq = 1'h0;
    n = 0;
    while (busPins.holdGrant && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    chk("bus regained", {1'h0, 1'h1}, {busPins.holdGrant, busPins.busOe});
  endtask : testHold

  task automatic awaitVector(output int acks);
    int n;
    logic wasIdle;
    n = 0;
    acks = 0;
    wasIdle = 1'h1;
    while (!irqVecValid && n < 80) begin
      @(negedge core_clk);
      n++;
      if (wasIdle && busPins.statusN !== STATUS_IDLE) begin
        acks++;
        chk("ack code", {CODE_IRQ_ACK, 1'h0}, {busPins.codeAck, busPins.memIo,
            busPins.statusN, busPins.lockN});
      end
      wasIdle = busPins.statusN === STATUS_IDLE;
    end
    chk("vector valid", 1'h1, irqVecValid);
  endtask : awaitVector

  task automatic testIrq;
    int n, acks;
    maskableIrq = 1'h1;
    rdWord = 16'hBE6D;
    repeat (12) @(negedge core_clk);
    pulseEnd();
    n = 0;
    acks = 0;
    repeat (30) begin
      @(negedge core_clk);
      if (irqVecValid) n++;
      if (busPins.statusN !== STATUS_IDLE) acks++;
    end
    chk("masked", 0, {n[15:0], acks[15:0]});
    flagsWord = 16'h0200;
    repeat (4) @(negedge core_clk);
    pulseEnd();
    awaitVector(acks);
    maskableIrq = 1'h0;
    chk("ack count", 2, acks);
    chk("vector", 8'h6D, irqVector);
    flagsWord = 16'h0000;
    nmiReq = 1'h1;
    repeat (8) @(negedge core_clk);
    pulseEnd();
    awaitVector(acks);
    nmiReq = 1'h0;
    chk("nmi acks", 0, acks);
    chk("nmi vector", 8'h02, irqVector);
  endtask : testIrq

  task automatic testCoproc;
    int n;
    waitInstr = 1'h1;
    coprocBusyN = 1'h0;
    coprocOperandRequest = 1'h1;
    repeat (6) @(negedge core_clk);
    chk("stall", 2'h3, {execStall, coprocOpPending});
    coprocBusyN = 1'h1;
    repeat (6) @(negedge core_clk);
    chk("stall end", 1'h0, execStall);
    coprocErrorN = 1'h0;
    n = 0;
    repeat (10) begin
      @(negedge core_clk);
      if (coprocErrIrq) n++;
    end
    chk("error irq", 1, n);
    coprocErrorN = 1'h1;
    waitInstr = 1'h0;
    coprocOperandRequest = 1'h0;
  endtask : testCoproc

  initial begin
    int n;
    repeat (10) @(negedge core_clk);
    chk("reset pins", {2'h3, 3'h1, 24'hFFFFFF, 4'h9}, {busPins.statusN, busPins.memIo,
        busPins.codeAck, busPins.lockN, busPins.addr, busPins.upperN, busPins.dataOe,
        busPins.holdGrant, busPins.opAckN});
    reset = 1'h0;
    n = 0;
    while (!startFetch && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    chk("init length", 50, n);
    testCycles();
    testHold();
    testIrq();
    testCoproc();
    final_report();
  end

  initial begin
    #(3000 * 50);
    n_fail++;
    final_report();
  end
endmodule : cpu_bus_system_interface_test
`default_nettype wire
